// file: core/rcb_pkg.sv
// Constants, field layouts and carrier types for the reading capture buffer.
// Assumes one 25 MHz clock and a register port with read data one cycle later.
// Overview of operation
// - Memory holds 1024 entries with reading, time stamp.
// - Nonzero count stops capture after that many writes.
// - Count zero selects never-ending continuous capture.
// - Continuous capture wraps pointer, overwriting oldest entries.
// - Multi-trigger spacing equals programmed interval, 10ms-999999ms.
// - Multi-trigger capture begins at once on start.
// - Indicator blinks while active, steady when done.
// - Halt stops capture; stored entries stay readable.
// - Starting capture empties the buffer.
// - Settings change aborts conversion unstored, restarts one.
// - Each entry keeps range and resolution with its reading.
// - Count above 1024 rejected, error flag raised.
// - One-shot stores one reading per key or external trigger.
// - One-shot waits programmed delay before each acquisition.
// - Trigger during processing flags overrun, reading continues.
// - One-shot count 0 to 1024; start arms capture.
// - Entries readable while running and after stop.
// - Time stamp clears on start, runs from first trigger.
package rcb_pkg;

	// Storage geometry.
	localparam int unsigned DEPTH = 1024;
	localparam logic [10:0] COUNT_MAX = 11'h400;
	localparam logic [31:0] COUNT_LIMIT = 32'h0000_0400;

	// Timing: every timer and the time stamp count in one millisecond steps.
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [19:0] INTERVAL_MIN_MS = 20'h0000a;
	localparam logic [19:0] INTERVAL_MAX_MS = 20'hf423f;
	localparam logic [19:0] DELAY_MIN_MS = 20'h00000;
	localparam logic [19:0] DELAY_MAX_MS = 20'hf423f;
	localparam logic [7:0] BLINK_MS = 8'hfa;

	// Reset values.
	localparam logic [19:0] INTERVAL_RESET = 20'h000fa;
	localparam logic [19:0] DELAY_RESET = 20'h00000;
	localparam logic [10:0] COUNT_RESET = 11'h000;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_INTERVAL = 8'h08;
	localparam logic [7:0] OFF_DELAY = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_RD_INDEX = 8'h14;
	localparam logic [7:0] OFF_RD_DATA = 8'h18;
	localparam logic [7:0] OFF_RD_TIME = 8'h1c;
	localparam logic [7:0] OFF_WR_PTR = 8'h20;

	// Control register fields.
	localparam int unsigned CTRL_ONESHOT_BIT = 0;
	localparam int unsigned CTRL_EXTEN_BIT = 1;
	localparam int unsigned CTRL_START_BIT = 4;
	localparam int unsigned CTRL_HALT_BIT = 5;

	// Status register fields.
	localparam int unsigned STAT_ACTIVE_BIT = 0;
	localparam int unsigned STAT_DONE_BIT = 1;
	localparam int unsigned STAT_OVERRUN_BIT = 2;
	localparam int unsigned STAT_CNTERR_BIT = 3;
	localparam int unsigned STAT_FILL_LSB = 16;

	// Read data word fields.
	localparam int unsigned DATA_VALID_BIT = 31;

	// Register port request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} rcb_bus_req_s;

	// Converter result.
	typedef struct packed {
		logic ovf;
		logic [23:0] value;
	} rcb_result_s;

	// One stored entry.
	typedef struct packed {
		logic ovf;
		logic [2:0] range;
		logic [1:0] res;
		logic [23:0] value;
		logic [29:0] stamp;
	} rcb_entry_s;

	// Acquisition sequencer states.
	typedef enum logic [2:0] {
		ACQ_IDLE = 3'b001,
		ACQ_DELAY = 3'b010,
		ACQ_CONV = 3'b100
	} rcb_acq_e;

endpackage

// file: core/rcb_top.sv
// Reading capture buffer: trigger sequencing, conversion handshake, capture memory.
// Assumes the converter, settings and register port share clock_in; the
// manual key and external trigger are asynchronous pins.
//
// The register addresses and the strobed register port were decided locally.
module rcb_top #(
	parameter int unsigned TICK_CYCLES = rcb_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Register port
	input wire rcb_pkg::rcb_bus_req_s bus_req_in,
	output logic [31:0] bus_rdata_out,
	// Converter
	output logic conv_start_out,
	output logic conv_abort_out,
	output logic conv_ready_out,
	input wire logic conv_valid_in,
	input wire rcb_pkg::rcb_result_s conv_result_in,
	// Measurement settings
	input wire logic [2:0] range_in,
	input wire logic [1:0] res_in,
	input wire logic settings_change_in,
	// Trigger pins
	input wire logic manual_key_in,
	input wire logic ext_trig_in,
	// Indicators
	output logic store_led_out,
	output logic capture_active_out,
	output logic overrun_out
);

	// Clamps a programmed time into its legal range.
	function automatic logic [19:0] clamp_ms(input logic [31:0] v, input logic [19:0] lo,
			input logic [19:0] hi);
		logic [19:0] r;
		r = v[19:0];
		if (v > {12'h000, hi}) begin
			r = hi;
		end else if (v < {12'h000, lo}) begin
			r = lo;
		end
		return r;
	endfunction

	// Configuration, flags, counters and timers.
	logic one_shot_reg, ext_en_reg, cnt_err_reg, overrun_reg, ts_run_reg, blink_phase_reg;
	logic cap_active_reg, cap_done_reg, buf_wr_reg, buf_rd_reg;
	logic [1:0] buf_cnt_reg, buf_cnt_next;
	logic [10:0] count_reg, fill_reg, written_reg;
	logic [19:0] interval_reg, delay_reg, ivl_cnt_reg, dly_cnt_reg;
	logic [9:0] rd_index_reg, wr_ptr_reg;
	logic [29:0] ts_reg, stamp_reg;
	logic [15:0] tick_cnt_reg;
	logic [2:0] man_sync_reg, ext_sync_reg;
	logic [7:0] blink_cnt_reg;
	logic [31:0] status_word;
	rcb_pkg::rcb_acq_e acq_reg;
	// The capture memory is not reset; the fill level marks which entries hold data.
	rcb_pkg::rcb_entry_s buf_mem [2];
	rcb_pkg::rcb_entry_s cap_mem [rcb_pkg::DEPTH];
	rcb_pkg::rcb_entry_s rd_entry;

	// Register port decode.
	logic wr_ctrl, wr_status, start_cmd, halt_cmd, mem_rd_hit;
	assign wr_ctrl = bus_req_in.wr && (bus_req_in.addr == rcb_pkg::OFF_CTRL);
	assign wr_status = bus_req_in.wr && (bus_req_in.addr == rcb_pkg::OFF_STATUS);
	assign start_cmd = wr_ctrl && bus_req_in.wdata[rcb_pkg::CTRL_START_BIT];
	assign halt_cmd = wr_ctrl && bus_req_in.wdata[rcb_pkg::CTRL_HALT_BIT];
	assign mem_rd_hit = bus_req_in.rd && ((bus_req_in.addr == rcb_pkg::OFF_RD_DATA) ||
		(bus_req_in.addr == rcb_pkg::OFF_RD_TIME));

	// Millisecond tick; restarted on start so the first interval is full length.
	logic tick;
	assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tick_cnt_reg <= 16'h0000;
		end else if (start_cmd || tick) begin
			tick_cnt_reg <= 16'h0000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
		end
	end

	// Trigger pin synchronisers; edges are taken only from the settled stages.
	logic man_edge, ext_edge;
	assign man_edge = man_sync_reg[1] && !man_sync_reg[2];
	assign ext_edge = ext_sync_reg[1] && !ext_sync_reg[2];
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			man_sync_reg <= 3'h0;
			ext_sync_reg <= 3'h0;
		end else begin
			man_sync_reg <= {man_sync_reg[1:0], manual_key_in};
			ext_sync_reg <= {ext_sync_reg[1:0], ext_trig_in};
		end
	end

	// Trigger sources: interval timer in multi mode, key or pin in one-shot mode.
	logic ivl_fire, trig_evt;
	assign ivl_fire = cap_active_reg && !one_shot_reg && (ivl_cnt_reg == 20'h00000);
	assign trig_evt = cap_active_reg && (one_shot_reg ? (man_edge || (ext_en_reg && ext_edge)) :
		ivl_fire);

	// Interval timer; it sits at zero after start so the first reading is taken at once.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ivl_cnt_reg <= 20'h00000;
		end else if (start_cmd) begin
			ivl_cnt_reg <= 20'h00000;
		end else if (ivl_fire) begin
			ivl_cnt_reg <= interval_reg;
		end else if (tick && (ivl_cnt_reg != 20'h00000)) begin
			ivl_cnt_reg <= ivl_cnt_reg - 20'h00001;
		end
	end

	// Elapsed time since the first trigger of this capture, in milliseconds.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ts_run_reg <= 1'b0;
			ts_reg <= 30'h00000000;
		end else if (start_cmd) begin
			ts_run_reg <= 1'b0;
			ts_reg <= 30'h00000000;
		end else begin
			if (trig_evt) begin
				ts_run_reg <= 1'b1;
			end
			if (ts_run_reg && tick) begin
				ts_reg <= ts_reg + 30'h00000001;
			end
		end
	end

	// Converter result accepted into the buffer.
	logic push, pop;
	assign push = (acq_reg == rcb_pkg::ACQ_CONV) && cap_active_reg && !settings_change_in &&
		conv_valid_in && conv_ready_out;

	// Acquisition sequencer: optional delay, conversion, abort and restart.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			acq_reg <= rcb_pkg::ACQ_IDLE;
			dly_cnt_reg <= 20'h00000;
			stamp_reg <= 30'h00000000;
			conv_start_out <= 1'b0;
			conv_abort_out <= 1'b0;
		end else begin
			conv_start_out <= 1'b0;
			conv_abort_out <= 1'b0;
			unique case (acq_reg)
				rcb_pkg::ACQ_IDLE: begin
					if (trig_evt && one_shot_reg && (delay_reg != 20'h00000)) begin
						acq_reg <= rcb_pkg::ACQ_DELAY;
						dly_cnt_reg <= delay_reg;
					end else if (trig_evt) begin
						acq_reg <= rcb_pkg::ACQ_CONV;
						conv_start_out <= 1'b1;
						stamp_reg <= ts_reg;
					end
				end
				rcb_pkg::ACQ_DELAY: begin
					if (!cap_active_reg) begin
						acq_reg <= rcb_pkg::ACQ_IDLE;
					end else if (dly_cnt_reg == 20'h00000) begin
						acq_reg <= rcb_pkg::ACQ_CONV;
						conv_start_out <= 1'b1;
						stamp_reg <= ts_reg;
					end else if (tick) begin
						dly_cnt_reg <= dly_cnt_reg - 20'h00001;
					end
				end
				rcb_pkg::ACQ_CONV: begin
					if (!cap_active_reg) begin
						acq_reg <= rcb_pkg::ACQ_IDLE;
						conv_abort_out <= 1'b1;
					end else if (settings_change_in) begin
						conv_abort_out <= 1'b1;
						conv_start_out <= 1'b1;
						stamp_reg <= ts_reg;
					end else if (push) begin
						acq_reg <= rcb_pkg::ACQ_IDLE;
					end
				end
			endcase
		end
	end

	// Overrun flag: a trigger while busy is flagged but the reading is kept.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			overrun_reg <= 1'b0;
		end else if (trig_evt && (acq_reg != rcb_pkg::ACQ_IDLE)) begin
			overrun_reg <= 1'b1;
		end else if (wr_status && bus_req_in.wdata[rcb_pkg::STAT_OVERRUN_BIT]) begin
			overrun_reg <= 1'b0;
		end
	end

	// Two-entry buffer between converter and memory; a read of the data or time register stalls the drain.
	assign pop = (buf_cnt_reg != 2'h0) && !mem_rd_hit;
	always_comb begin
		buf_cnt_next = buf_cnt_reg;
		if (start_cmd) begin
			buf_cnt_next = 2'h0;
		end else if (push && !pop) begin
			buf_cnt_next = buf_cnt_reg + 2'h1;
		end else if (pop && !push) begin
			buf_cnt_next = buf_cnt_reg - 2'h1;
		end
	end

	// Buffer pointers; ready is registered from the next fill so it is exact.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			buf_wr_reg <= 1'b0;
			buf_rd_reg <= 1'b0;
			buf_cnt_reg <= 2'h0;
			conv_ready_out <= 1'b1;
		end else begin
			buf_cnt_reg <= buf_cnt_next;
			conv_ready_out <= (buf_cnt_next != 2'h2);
			if (start_cmd) begin
				buf_wr_reg <= 1'b0;
				buf_rd_reg <= 1'b0;
			end else begin
				if (push) begin
					buf_wr_reg <= !buf_wr_reg;
				end
				if (pop) begin
					buf_rd_reg <= !buf_rd_reg;
				end
			end
		end
	end

	// Buffer storage; only the present range and resolution go with the reading.
	always_ff @(posedge clock_in) begin
		if (push) begin
			buf_mem[buf_wr_reg] <= '{ovf: conv_result_in.ovf, range: range_in, res: res_in,
				value: conv_result_in.value, stamp: stamp_reg};
		end
	end

	// Capture state, write pointer and fill level.
	logic store;
	assign store = pop && cap_active_reg;
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cap_active_reg <= 1'b0;
			cap_done_reg <= 1'b0;
			wr_ptr_reg <= 10'h000;
			fill_reg <= 11'h000;
			written_reg <= 11'h000;
		end else if (start_cmd) begin
			cap_active_reg <= 1'b1;
			cap_done_reg <= 1'b0;
			wr_ptr_reg <= 10'h000;
			fill_reg <= 11'h000;
			written_reg <= 11'h000;
		end else begin
			if (store) begin
				wr_ptr_reg <= wr_ptr_reg + 10'h001;
				written_reg <= written_reg + 11'h001;
				if (fill_reg != rcb_pkg::COUNT_MAX) begin
					fill_reg <= fill_reg + 11'h001;
				end
				if ((count_reg != 11'h000) && (written_reg + 11'h001 == count_reg)) begin
					cap_active_reg <= 1'b0;
					cap_done_reg <= 1'b1;
				end
			end
			if (halt_cmd) begin
				cap_active_reg <= 1'b0;
			end
		end
	end

	// Capture memory write port; entries persist until their location is written again.
	always_ff @(posedge clock_in) begin
		if (store) begin
			cap_mem[wr_ptr_reg] <= buf_mem[buf_rd_reg];
		end
	end

	// Configuration registers.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			one_shot_reg <= 1'b0;
			ext_en_reg <= 1'b0;
			count_reg <= rcb_pkg::COUNT_RESET;
			interval_reg <= rcb_pkg::INTERVAL_RESET;
			delay_reg <= rcb_pkg::DELAY_RESET;
			rd_index_reg <= 10'h000;
		end else if (bus_req_in.wr) begin
			unique case (bus_req_in.addr)
				rcb_pkg::OFF_CTRL: begin
					one_shot_reg <= bus_req_in.wdata[rcb_pkg::CTRL_ONESHOT_BIT];
					ext_en_reg <= bus_req_in.wdata[rcb_pkg::CTRL_EXTEN_BIT];
				end
				rcb_pkg::OFF_COUNT: begin
					if (bus_req_in.wdata <= rcb_pkg::COUNT_LIMIT) begin
						count_reg <= bus_req_in.wdata[10:0];
					end
				end
				rcb_pkg::OFF_INTERVAL: begin
					interval_reg <= clamp_ms(bus_req_in.wdata, rcb_pkg::INTERVAL_MIN_MS,
						rcb_pkg::INTERVAL_MAX_MS);
				end
				rcb_pkg::OFF_DELAY: begin
					delay_reg <= clamp_ms(bus_req_in.wdata, rcb_pkg::DELAY_MIN_MS,
						rcb_pkg::DELAY_MAX_MS);
				end
				rcb_pkg::OFF_RD_INDEX: begin
					rd_index_reg <= bus_req_in.wdata[9:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Count error flag; an oversize count sets it, software clears it by writing one.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_err_reg <= 1'b0;
		end else if (bus_req_in.wr && (bus_req_in.addr == rcb_pkg::OFF_COUNT) &&
				(bus_req_in.wdata > rcb_pkg::COUNT_LIMIT)) begin
			cnt_err_reg <= 1'b1;
		end else if (wr_status && bus_req_in.wdata[rcb_pkg::STAT_CNTERR_BIT]) begin
			cnt_err_reg <= 1'b0;
		end
	end

	// Store indicator: blinks while capturing, steady once a finite run completes.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			blink_cnt_reg <= 8'h00;
			blink_phase_reg <= 1'b0;
			store_led_out <= 1'b0;
			capture_active_out <= 1'b0;
			overrun_out <= 1'b0;
		end else begin
			if (tick && (blink_cnt_reg == rcb_pkg::BLINK_MS - 8'h01)) begin
				blink_cnt_reg <= 8'h00;
				blink_phase_reg <= !blink_phase_reg;
			end else if (tick) begin
				blink_cnt_reg <= blink_cnt_reg + 8'h01;
			end
			store_led_out <= cap_active_reg ? blink_phase_reg : cap_done_reg;
			capture_active_out <= cap_active_reg;
			overrun_out <= overrun_reg;
		end
	end

	// Status word assembly.
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[rcb_pkg::STAT_ACTIVE_BIT] = cap_active_reg;
		status_word[rcb_pkg::STAT_DONE_BIT] = cap_done_reg;
		status_word[rcb_pkg::STAT_OVERRUN_BIT] = overrun_reg;
		status_word[rcb_pkg::STAT_CNTERR_BIT] = cnt_err_reg;
		status_word[rcb_pkg::STAT_FILL_LSB +: 11] = fill_reg;
	end

	// Read path works during and after capture; the drain yields on these cycles.
	assign rd_entry = cap_mem[rd_index_reg];
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_rdata_out <= 32'h0000_0000;
		end else begin
			bus_rdata_out <= 32'h0000_0000;
			if (bus_req_in.rd) begin
				unique case (bus_req_in.addr)
					rcb_pkg::OFF_CTRL: begin
						bus_rdata_out[rcb_pkg::CTRL_ONESHOT_BIT] <= one_shot_reg;
						bus_rdata_out[rcb_pkg::CTRL_EXTEN_BIT] <= ext_en_reg;
					end
					rcb_pkg::OFF_COUNT: bus_rdata_out <= {21'h000000, count_reg};
					rcb_pkg::OFF_INTERVAL: bus_rdata_out <= {12'h000, interval_reg};
					rcb_pkg::OFF_DELAY: bus_rdata_out <= {12'h000, delay_reg};
					rcb_pkg::OFF_STATUS: bus_rdata_out <= status_word;
					rcb_pkg::OFF_RD_INDEX: bus_rdata_out <= {22'h000000, rd_index_reg};
					rcb_pkg::OFF_RD_DATA: begin
						bus_rdata_out[29:0] <= {rd_entry.ovf, rd_entry.range, rd_entry.res,
							rd_entry.value};
						bus_rdata_out[rcb_pkg::DATA_VALID_BIT] <= ({1'b0, rd_index_reg} < fill_reg);
					end
					rcb_pkg::OFF_RD_TIME: bus_rdata_out <= {2'h0, rd_entry.stamp};
					rcb_pkg::OFF_WR_PTR: bus_rdata_out <= {22'h000000, wr_ptr_reg};
					default: bus_rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// file: bench/rcb_top_assertions.sv
// Port-level checks for the reading capture buffer.
// Assumes one clock domain and a bind into rcb_top from the bench top file.
module rcb_top_assertions #(
	parameter int unsigned TICK_CYCLES = 10
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Register port
	input wire rcb_pkg::rcb_bus_req_s bus_req_in,
	input wire logic [31:0] bus_rdata_out,
	// Converter and settings
	input wire logic conv_start_out,
	input wire logic conv_abort_out,
	input wire logic settings_change_in,
	// Indicators
	input wire logic store_led_out,
	input wire logic capture_active_out,
	input wire logic overrun_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ovr_clr;
	logic led_q;
	logic [31:0] still_reg;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);
	// A status write with the overrun bit set is the only way to clear the flag.
	assign ovr_clr = bus_req_in.wr && bus_req_in.addr == rcb_pkg::OFF_STATUS
		&& bus_req_in.wdata[rcb_pkg::STAT_OVERRUN_BIT];
	// Count how long the indicator holds one level while a run is active.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			led_q <= 1'b0;
			still_reg <= 32'h0;
		end else begin
			led_q <= store_led_out;
			still_reg <= (!capture_active_out || store_led_out != led_q) ? 32'h0 : still_reg + 32'h1;
		end
	end
	sequence restart_s;
		conv_abort_out && conv_start_out;
	endsequence
	sequence stopped_s;
		!capture_active_out [*3];
	endsequence
	rdata_idle_a: assert property (!bus_req_in.rd |=> bus_rdata_out == 32'h0)
		else $error("read data present without a read");
	start_pulse_a: assert property (conv_start_out && !settings_change_in |=> !conv_start_out)
		else $error("conversion start longer than one cycle");
	abort_pulse_a: assert property (conv_abort_out && !settings_change_in |=> !conv_abort_out)
		else $error("conversion abort longer than one cycle");
	restart_cause_a: assert property (restart_s |-> $past(settings_change_in) || $past(settings_change_in, 2))
		else $error("abort with restart but no settings change");
	idle_quiet_a: assert property (!capture_active_out [*2] |-> !conv_start_out)
		else $error("conversion started while capture stopped");
	overrun_hold_a: assert property (overrun_out && !ovr_clr && !$past(ovr_clr) |=> overrun_out)
		else $error("overrun flag dropped without a clear");
	led_steady_a: assert property (stopped_s ##0 store_led_out |=> (store_led_out || capture_active_out) [*4])
		else $error("done indicator not steady");
	blink_live_a: assert property (still_reg <= 250 * TICK_CYCLES + 2)
		else $error("indicator stopped blinking during a run");
endmodule

// file: bench/rcb_conv_model.sv
// Behavioural converter that answers each start after a set latency.
// Assumes start and abort are one-cycle pulses on the shared clock.
module rcb_conv_model (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Converter handshake
	input wire logic conv_start_in,
	input wire logic conv_abort_in,
	input wire logic conv_ready_in,
	input wire logic [7:0] latency_in,
	output logic conv_valid_out,
	output rcb_pkg::rcb_result_s conv_result_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy_reg;
	logic [7:0] wait_reg;
	logic [23:0] seq_reg;
	// Each start takes the next sequence value, so stored entries count upward.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_reg <= 1'b0;
			wait_reg <= 8'h0;
			seq_reg <= 24'h0;
			conv_valid_out <= 1'b0;
			conv_result_out <= '0;
		end else if (conv_start_in) begin
			busy_reg <= 1'b1;
			wait_reg <= latency_in;
			conv_valid_out <= 1'b0;
			seq_reg <= seq_reg + 24'h1;
		end else if (conv_abort_in) begin
			busy_reg <= 1'b0;
			conv_valid_out <= 1'b0;
		end else if (conv_valid_out && conv_ready_in) begin
			// A taken result is not left on the lines; the inverse shows it is stale.
			conv_valid_out <= 1'b0;
			conv_result_out <= ~conv_result_out;
		end else if (busy_reg && wait_reg == 8'h0) begin
			busy_reg <= 1'b0;
			conv_valid_out <= 1'b1;
			conv_result_out <= {1'b0, seq_reg};
		end else if (busy_reg) begin
			wait_reg <= wait_reg - 8'h1;
		end
	end
endmodule

// file: bench/rcb_top_tb.sv
// Self-checking bench for the reading capture buffer.
// Assumes rcb_conv_model stands in for the converter; the bench drives keys and registers.
module rcb_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned TK = 4;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	rcb_pkg::rcb_bus_req_s bus_req_in = '0;
	logic [31:0] bus_rdata_out;
	logic conv_start_out, conv_abort_out, conv_ready_out, conv_valid_in;
	rcb_pkg::rcb_result_s conv_result_in;
	logic [2:0] range_in = 3'h0;
	logic [1:0] res_in = 2'h0;
	logic settings_change_in = 1'b0, manual_key_in = 1'b0, ext_trig_in = 1'b0;
	logic store_led_out, capture_active_out, overrun_out, l;
	logic [7:0] lat = 8'h02;
	logic [31:0] seed = 32'h35, d, e, p, cnt;
	int errors = 0, checks_done = 0, n;
	rcb_top #(.TICK_CYCLES(TK)) dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out),
		.conv_start_out(conv_start_out), .conv_abort_out(conv_abort_out),
		.conv_ready_out(conv_ready_out), .conv_valid_in(conv_valid_in),
		.conv_result_in(conv_result_in), .range_in(range_in), .res_in(res_in),
		.settings_change_in(settings_change_in), .manual_key_in(manual_key_in),
		.ext_trig_in(ext_trig_in), .store_led_out(store_led_out),
		.capture_active_out(capture_active_out), .overrun_out(overrun_out));
	rcb_conv_model conv (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.conv_start_in(conv_start_out), .conv_abort_in(conv_abort_out),
		.conv_ready_in(conv_ready_out), .latency_in(lat),
		.conv_valid_out(conv_valid_in), .conv_result_out(conv_result_in));
	// Free-running 25 MHz clock.
	always #20 clock_in = ~clock_in;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Expected status and entry words, built field by field.
	function automatic logic [31:0] st(input logic a, dn, o, c, input logic [10:0] f);
		return {5'h0, f, 12'h0, c, o, dn, a};
	endfunction
	function automatic logic [31:0] ent(input logic [2:0] r, input logic [1:0] s, input logic [23:0] v);
		return {1'b1, 1'b0, 1'b0, r, s, v};
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_in);
		bus_req_in <= '{1'b1, 1'b0, a, v};
		@(posedge clock_in);
		bus_req_in.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock_in);
		bus_req_in <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clock_in);
		bus_req_in.rd <= 1'b0;
		#1 v = bus_rdata_out;
	endtask
	// An earlier start pulse is still visible at the edge, so look only after one.
	task automatic wait_start(input int lim);
		n = 0;
		do begin
			@(posedge clock_in);
			#1;
			n++;
		end while (conv_start_out !== 1'b1 && n < lim);
	endtask
	task automatic trig(input logic ext);
		@(posedge clock_in);
		if (ext) ext_trig_in <= 1'b1;
		else manual_key_in <= 1'b1;
		wait_start(400);
		manual_key_in <= 1'b0;
		ext_trig_in <= 1'b0;
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Cut a hang short well past the expected run length.
	initial begin
		#(40 * 80000);
		errors++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge clock_in);
		rst_b_in <= 1'b1;
		// Oversized count is refused and flagged; the limit itself is taken.
		wr(rcb_pkg::OFF_COUNT, 32'h401);
		rd(rcb_pkg::OFF_COUNT, d);
		chk("count_refused", d, 32'h0);
		rd(rcb_pkg::OFF_STATUS, d);
		chk("cnterr", d, st(0, 0, 0, 1, 0));
		wr(rcb_pkg::OFF_STATUS, 32'h8);
		wr(rcb_pkg::OFF_COUNT, 32'h400);
		rd(rcb_pkg::OFF_COUNT, d);
		chk("count_max", d, 32'h400);
		// Finite multi-trigger run at the shortest interval with random settings.
		seed = xs(seed);
		range_in <= seed[2:0];
		res_in <= seed[4:3];
		cnt = {30'h0, seed[6:5]} + 32'h2;
		wr(rcb_pkg::OFF_INTERVAL, 32'h0);
		wr(rcb_pkg::OFF_COUNT, cnt);
		wr(rcb_pkg::OFF_CTRL, 32'h10);
		rd(rcb_pkg::OFF_STATUS, d);
		chk("started", 32'(d[1:0]), 32'h1);
		for (int i = 0; i < 300 && !d[1]; i++) rd(rcb_pkg::OFF_STATUS, d);
		chk("finite_done", d, st(0, 1, 0, 0, cnt[10:0]));
		chk("led_on", 32'(store_led_out), 32'h1);
		for (int k = 0; k <= cnt; k++) begin
			wr(rcb_pkg::OFF_RD_INDEX, k);
			rd(rcb_pkg::OFF_RD_DATA, d);
			rd(rcb_pkg::OFF_RD_TIME, e);
			if (k < cnt) chk("entry", d, ent(range_in, res_in, 24'(k + 1)));
			if (k < cnt) chk("stamp", 32'(e + 32'h1 >= 10 * k && e <= 10 * k + 1), 32'h1);
			else chk("empty", 32'(d[31]), 32'h0);
		end
		repeat (100) @(posedge clock_in);
		rd(rcb_pkg::OFF_WR_PTR, d);
		chk("no_write_after_done", d, cnt);
		// Continuous run: wraps, saturates and keeps blinking until halted.
		wr(rcb_pkg::OFF_COUNT, 32'h0);
		wr(rcb_pkg::OFF_CTRL, 32'h10);
		rd(rcb_pkg::OFF_STATUS, d);
		chk("cleared", 32'(d[26:16]), 32'h0);
		p = 32'h0;
		for (int i = 0; i < 25000; i++) begin
			rd(rcb_pkg::OFF_WR_PTR, e);
			if (e < p) break;
			p = e;
		end
		chk("wrapped", 32'(e < p), 32'h1);
		rd(rcb_pkg::OFF_STATUS, d);
		chk("full_running", d, st(1, 0, 0, 0, 11'h400));
		wr(rcb_pkg::OFF_RD_INDEX, 32'h0);
		rd(rcb_pkg::OFF_RD_DATA, d);
		chk("read_running", 32'(d[31]), 32'h1);
		l = store_led_out;
		repeat (250 * TK) @(posedge clock_in);
		#1 chk("blink", 32'(store_led_out != l), 32'h1);
		wr(rcb_pkg::OFF_CTRL, 32'h20);
		repeat (4) @(posedge clock_in);
		rd(rcb_pkg::OFF_WR_PTR, p);
		repeat (200) @(posedge clock_in);
		rd(rcb_pkg::OFF_WR_PTR, e);
		chk("halted_ptr", e, p);
		rd(rcb_pkg::OFF_STATUS, d);
		chk("halted", d, st(0, 0, 0, 0, 11'h400));
		chk("pins_halted", 32'({conv_ready_out, capture_active_out, overrun_out}), 32'h4);
		// One-shot with delay and a slow converter; a second trigger overruns.
		lat <= 8'h20;
		wr(rcb_pkg::OFF_DELAY, 32'h5);
		wr(rcb_pkg::OFF_COUNT, 32'h2);
		wr(rcb_pkg::OFF_CTRL, 32'h13);
		rd(rcb_pkg::OFF_STATUS, d);
		chk("armed", d, st(1, 0, 0, 0, 0));
		trig(1'b0);
		chk("delay", 32'(n >= 5 * TK && n <= 5 * TK + 8), 32'h1);
		trig(1'b1);
		rd(rcb_pkg::OFF_STATUS, d);
		chk("overrun", d, st(1, 0, 1, 0, 1));
		chk("overrun_pin", 32'(overrun_out), 32'h1);
		trig(1'b1);
		repeat (80) @(posedge clock_in);
		rd(rcb_pkg::OFF_STATUS, d);
		chk("oneshot_done", d, st(0, 1, 1, 0, 2));
		// A settings change mid-conversion restarts it.
		wr(rcb_pkg::OFF_STATUS, 32'h4);
		lat <= 8'h10;
		wr(rcb_pkg::OFF_COUNT, 32'h0);
		wr(rcb_pkg::OFF_CTRL, 32'h10);
		wait_start(200);
		settings_change_in <= 1'b1;
		@(posedge clock_in);
		#1 settings_change_in <= 1'b0;
		for (int i = 0; i < 4 && conv_abort_out !== 1'b1; i++) @(posedge clock_in) #1;
		chk("restart", 32'({conv_abort_out, conv_start_out}), 32'h3);
		wr(rcb_pkg::OFF_CTRL, 32'h20);
		summarize();
	end
endmodule
bind rcb_top rcb_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock_in(clock_in),
	.rst_b_in(rst_b_in), .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out),
	.conv_start_out(conv_start_out), .conv_abort_out(conv_abort_out),
	.settings_change_in(settings_change_in), .store_led_out(store_led_out),
	.capture_active_out(capture_active_out), .overrun_out(overrun_out));
